// >>> didb_top.sv
// Digital input debounce, status words and output 0 source select
// Register map, byte addresses, one 32-bit word each:
//   0x00 plain input status, read only
//   0x04 inverted input status, read only
//   0x08 debounce time in microseconds, read/write
//   0x0C output 0 source select, read/write
//   0x10 protection settings, read/write
//   0x14 output 0 state, read only
// Address bits above bit 7 fold onto an unmapped slot,
// so the short decode never aliases a register higher up.
// Refused writes answer with a slave error and change nothing.
// Debounce counts are whole sample periods; remainders are dropped.
// Terminal inputs are taken as synchronous to SYS_CLK.
// After reset the filtered levels are low, so the plain word
// reads zero and the inverted word reads ones in its used bits.
// The relay rests with its normally-closed contact made.
`timescale 1ns/1ps
module didb_top
    import didb_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [5:0] DI_IN,
    input wire logic [1:0] AI_DI_IN,
    input wire logic [15:0] DRIVE_STATUS_ONE,
    input wire logic [15:0] DRIVE_STATUS_TWO,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic DO0_NO,
    output logic DO0_NC
);
    localparam logic [16:0] SAMPLE_MAX = 17'(DIDB_SAMPLE_CYC - 1);
    localparam logic [7:0] NO_REG = 8'hFF; // Unaligned slot, decodes as unmapped
    localparam logic [31:0] SEL_MASK = 32'h0000_002F; // Word select and bit index fields

    logic [16:0] div_q; // Sample period divider
    logic tick_q; // 2 ms sample pulse
    logic slow_q; // Every second tick
    logic [31:0] deb_time_q; // Debounce time in microseconds
    logic [31:0] outsel_q; // Output 0 source select
    logic [1:0] prot_q; // Two protection settings
    logic [3:0] need; // Debounce sample count
    logic [DIDB_NUM_CH-1:0] raw; // Raw terminal levels
    logic [DIDB_NUM_CH-1:0] filt; // Debounced levels
    logic [31:0] plain_word; // Non-inverted status
    logic [31:0] inv_word; // Inverted status
    logic src_bit; // Selected source level
    // Write channel holding
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] wmask;
    logic [31:0] deb_new;
    logic wr_fire;
    logic deb_ok; // New debounce time in range
    logic sel_ok; // Output select not protected
    logic wr_err; // Pending write refused
    logic [7:0] rd_sel; // Read address after folding

    // Sample tick generator
    // One divider sets the 2 ms rate; slow_q halves it for the analog pair
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= 17'h0;
            tick_q <= 1'b0;
            slow_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (div_q == SAMPLE_MAX) begin
                div_q <= 17'h0;
                tick_q <= 1'b1;
                slow_q <= ~slow_q;
            end else begin
                div_q <= div_q + 17'h1;
            end
        end
    end

    // Debounce count: time over sample period, integer part
    // Zero or one both take the next differing sample
    assign need = 4'(deb_time_q / DIDB_SAMPLE_US_W);
    assign raw = {AI_DI_IN, DI_IN};

    // One filter per terminal
    // Analog-derived pair only samples on every second tick
    genvar gi;
    generate
        for (gi = 0; gi < DIDB_NUM_CH; gi++) begin : g_ch
            didb_filter didb_filter_i (
                .clk(SYS_CLK),
                .rst_n(RST_N),
                .sample_en(tick_q & ((gi < DIDB_NUM_DI) ? 1'b1 : slow_q)),
                .raw(raw[gi]),
                .need(need),
                .level_q(filt[gi])
            );
        end
    endgenerate

    // Status words from filtered levels
    // Unused bits read zero in both words
    always_comb begin
        plain_word = 32'h0;
        plain_word[DIDB_NUM_DI-1:0] = filt[DIDB_NUM_DI-1:0];
        plain_word[DIDB_AI0_BIT] = filt[6];
        plain_word[DIDB_AI1_BIT] = filt[7];
        inv_word = 32'h0;
        inv_word[DIDB_NUM_DI-1:0] = ~filt[DIDB_NUM_DI-1:0];
        inv_word[DIDB_AI0_BIT] = ~filt[6];
        inv_word[DIDB_AI1_BIT] = ~filt[7];
    end

    // Source mux over both drive status words
    assign src_bit = outsel_q[5] ? DRIVE_STATUS_TWO[outsel_q[3:0]]
                                 : DRIVE_STATUS_ONE[outsel_q[3:0]];

    // Relay contacts
    // Both contacts registered together, so they never overlap
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DO0_NO <= 1'b0;
            DO0_NC <= 1'b1;
        end else begin
            DO0_NO <= src_bit;
            DO0_NC <= ~src_bit;
        end
    end

    // Both halves held and no answer pending: the write takes effect
    assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;

    // Write address capture; high addresses fold onto an unmapped slot
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin // Address taken
            aw_have_q <= 1'b1;
            aw_addr_q <= (S_AXI_AWADDR[31:8] == 24'h0) ? S_AXI_AWADDR[7:0] : NO_REG;
        end else if (wr_fire) begin // Slot freed once the write lands
            aw_have_q <= 1'b0;
        end
    end

    // Write data capture, independent of the address channel
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin // Data taken
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
        end else if (wr_fire) begin // Slot freed once the write lands
            w_have_q <= 1'b0;
        end
    end

    // Ready while channel slot empty and no write answer pending
    // Readies drop the edge after a handshake, so a held slot is never overwritten
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_have_q && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_have_q && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
        end
    end

    // Byte mask from strobes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{w_strb_q[i]}};
        end
        deb_new = (deb_time_q & ~wmask) | (w_data_q & wmask);
    end

    // Range check and protection gate for the pending write
    assign deb_ok = (deb_new <= DIDB_DEB_MAX_US);
    assign sel_ok = (prot_q == 2'h0);

    // Debounce time register; out-of-range values leave it unchanged
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            deb_time_q <= DIDB_DEB_RST_US;
        end else if (wr_fire && aw_addr_q == DIDB_OFF_DEBOUNCE && deb_ok) begin
            deb_time_q <= deb_new;
        end
    end

    // Output 0 source select; unused bits always store zero
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            outsel_q <= DIDB_OUTSEL_RST;
        end else if (wr_fire && aw_addr_q == DIDB_OFF_OUTSEL && sel_ok) begin
            outsel_q <= ((outsel_q & ~wmask) | (w_data_q & wmask)) & SEL_MASK;
        end
    end

    // Protection settings, low byte only
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prot_q <= 2'h0;
        end else if (wr_fire && aw_addr_q == DIDB_OFF_PROT && w_strb_q[0]) begin
            prot_q <= w_data_q[1:0];
        end
    end

    // Refusal decode: read-only, unmapped, out of range or protected
    always_comb begin
        case (aw_addr_q)
            DIDB_OFF_DEBOUNCE: wr_err = !deb_ok;
            DIDB_OFF_OUTSEL: wr_err = !sel_ok;
            DIDB_OFF_PROT: wr_err = 1'b0; // Always writable
            default: wr_err = 1'b1; // Status words and unmapped
        endcase
    end

    // Write response; a new answer only after the last one was taken
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= DIDB_RESP_OKAY;
        end else begin
            if (S_AXI_BVALID && S_AXI_BREADY) begin // Answer taken
                S_AXI_BVALID <= 1'b0;
            end
            if (wr_fire) begin // Pair complete
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_err ? DIDB_RESP_SLVERR : DIDB_RESP_OKAY;
            end
        end
    end

    // Read address folding, same as on the write side
    // Keeps a high address from landing on a status word
    assign rd_sel = (S_AXI_ARADDR[31:8] == 24'h0) ? S_AXI_ARADDR[7:0] : NO_REG;

    // Read channel
    // One read in flight: ARREADY waits until the answer is taken
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= DIDB_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= DIDB_RESP_OKAY;
                case (rd_sel)
                    DIDB_OFF_PLAIN: S_AXI_RDATA <= plain_word;
                    DIDB_OFF_INV: S_AXI_RDATA <= inv_word;
                    DIDB_OFF_DEBOUNCE: S_AXI_RDATA <= deb_time_q;
                    DIDB_OFF_OUTSEL: S_AXI_RDATA <= outsel_q;
                    DIDB_OFF_PROT: S_AXI_RDATA <= {30'h0, prot_q};
                    DIDB_OFF_DOSTAT: S_AXI_RDATA <= {31'h0, DO0_NO};
                    default: begin // Unmapped
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= DIDB_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule : didb_top

// >>> didb_pkg.sv
// Package of constants and types for the input debounce and output select block
package didb_pkg;
    // Register byte addresses
    localparam logic [7:0] DIDB_OFF_PLAIN = 8'h00;
    localparam logic [7:0] DIDB_OFF_INV = 8'h04;
    localparam logic [7:0] DIDB_OFF_DEBOUNCE = 8'h08;
    localparam logic [7:0] DIDB_OFF_OUTSEL = 8'h0C;
    localparam logic [7:0] DIDB_OFF_PROT = 8'h10;
    localparam logic [7:0] DIDB_OFF_DOSTAT = 8'h14;
    // Terminal counts and bit positions
    localparam int DIDB_NUM_DI = 6;
    localparam int DIDB_AI0_BIT = 11;
    localparam int DIDB_AI1_BIT = 12;
    localparam int DIDB_NUM_CH = 8;
    // Clock and sampling times
    localparam int DIDB_CLK_HZ = 40000000;
    localparam int DIDB_SAMPLE_US = 2000;
    localparam int DIDB_SAMPLE_CYC = DIDB_CLK_HZ / 1000000 * DIDB_SAMPLE_US;
    // Debounce time in microseconds
    localparam logic [31:0] DIDB_DEB_MAX_US = 32'h0000_4E20;
    localparam logic [31:0] DIDB_DEB_RST_US = 32'h0000_0FA0;
    localparam logic [31:0] DIDB_SAMPLE_US_W = 32'h0000_07D0;
    // Output source select: [5] word (0 first, 1 second), [3:0] bit
    localparam logic [31:0] DIDB_OUTSEL_RST = 32'h0000_0003;
    // AXI responses
    localparam logic [1:0] DIDB_RESP_OKAY = 2'h0;
    localparam logic [1:0] DIDB_RESP_SLVERR = 2'h2;
endpackage : didb_pkg

// >>> didb_filter.sv
// One debounce channel: accepts a new level after enough stable samples
`timescale 1ns/1ps
module didb_filter
    import didb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_en,
    input wire logic raw,
    input wire logic [3:0] need,
    output logic level_q
);
    logic [3:0] cnt_q; // Stable sample count

    // Counts samples differing from the accepted level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            level_q <= 1'b0;
        end else if (sample_en) begin
            if (raw == level_q) begin
                cnt_q <= 4'h0;
            end else if (cnt_q + 4'h1 >= need) begin
                level_q <= raw;
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule : didb_filter

// >>> didb_top_assertions.sv
// Port-level checker for the input debounce and output select block
`timescale 1ns/1ps
module didb_top_checker
    import didb_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic DO0_NO,
    input wire logic DO0_NC
);
    logic [31:0] ra_q; // Last read address taken
    logic [31:0] wa_q; // Last write address taken
    // Remember addresses so answers can be judged
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ra_q <= 32'h0;
            wa_q <= 32'h0;
        end else begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) ra_q <= S_AXI_ARADDR;
            if (S_AXI_AWVALID && S_AXI_AWREADY) wa_q <= S_AXI_AWADDR;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    relay_pair_a: assert property (DO0_NC == !DO0_NO)
        else $error("Relay contacts not complementary");
    bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("Write response dropped early");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("Read data not held");
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("Read answer late");
    status_read_a: assert property (S_AXI_RVALID && (ra_q == 32'h0 || ra_q == 32'h4)
        |-> S_AXI_RRESP == DIDB_RESP_OKAY)
        else $error("Status word read refused");
    unmapped_read_a: assert property (S_AXI_RVALID && ra_q > 32'h14 |-> S_AXI_RRESP == DIDB_RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("Unmapped read not refused");
    status_write_a: assert property (S_AXI_BVALID && wa_q < 32'h8 |-> S_AXI_BRESP == DIDB_RESP_SLVERR)
        else $error("Status word write accepted");
    write_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("Write taken while response pending");
endmodule : didb_top_checker

// >>> didb_terminals.sv
// Terminal switches and relay load at the far side of the block
`timescale 1ns/1ps
module didb_terminals (
    input wire logic [7:0] closed, // Switch pattern, analog pair on top
    input wire logic relay_no,
    input wire logic relay_nc,
    output logic [5:0] di_level,
    output logic [1:0] ai_level,
    output logic relay_fault
);
    // A closed switch pulls its terminal high
    assign di_level = closed[5:0];
    assign ai_level = closed[7:6];
    // Both contacts made or both open means a broken relay
    assign relay_fault = relay_no ~^ relay_nc;
endmodule : didb_terminals

// >>> didb_top_test.sv
// Self-checking bench for the input debounce and output select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module didb_top_test;
    import didb_pkg::*;
    typedef struct {logic wr; logic [31:0] a; logic [31:0] d; logic [1:0] b; logic [31:0] q; logic [1:0] r;} didb_row_t;
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, dat;
    logic [15:0] ds1 = 16'h0;
    logic [15:0] ds2 = 16'h0;
    logic [7:0] sw = 8'h0;
    logic [5:0] di;
    logic [1:0] ai, bresp, rresp, rsp;
    logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, do_no, do_nc, fault;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    didb_row_t rows[9];
    didb_top didb_top_i (.SYS_CLK(clk), .RST_N(rst_n), .DI_IN(di), .AI_DI_IN(ai), .DRIVE_STATUS_ONE(ds1),
        .DRIVE_STATUS_TWO(ds2), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_rdy),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .DO0_NO(do_no), .DO0_NC(do_nc));
    didb_terminals didb_terminals_i (.closed(sw), .relay_no(do_no), .relay_nc(do_nc), .di_level(di),
        .ai_level(ai), .relay_fault(fault));
    // Clock and cycle count since reset release
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;
    // Bus write, both channels offered together
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_d;
        logic w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge clk);
            if (aw_rdy && !aw_d) begin
                awvalid <= 1'b0;
                aw_d = 1'b1;
            end
            if (w_rdy && !w_d) begin
                wvalid <= 1'b0;
                w_d = 1'b1;
            end
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axw
    // Bus read
    task automatic axr(input logic [31:0] a, output logic [1:0] r, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!ar_rdy);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        r = rresp;
        d = rdata;
        rready <= 1'b0;
    endtask : axr
    task conclude;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Hang guard
    initial begin
        #2500000;
        errors++;
        conclude();
    end
    initial begin
        rows = '{'{0, 32'h08, 0, 0, DIDB_DEB_RST_US, 0}, '{0, 32'h0C, 0, 0, DIDB_OUTSEL_RST, 0}, '{0, 32'h10, 0, 0, 0, 0},
            '{1, 32'h08, 32'h4E20, 0, 32'h4E20, 0}, '{1, 32'h08, 32'h4E21, 2, 32'h4E20, 0},
            '{1, 32'h0C, 32'h25, 0, 32'h25, 0}, '{1, 32'h04, 0, 2, 32'h183F, 0}, '{1, 32'h40, 1, 2, 0, 2},
            '{1, 32'h0C, 32'h02, 0, 32'h02, 0}};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // Register table: reset values, limits, read-only and unmapped places
        for (int i = 0; i < 9; i++) begin
            if (rows[i].wr) begin
                axw(rows[i].a, rows[i].d, rsp);
                `CHK("bresp", rows[i].b, rsp)
            end
            axr(rows[i].a, rsp, dat);
            `CHK("rresp", rows[i].r, rsp)
            `CHK("rdata", rows[i].q, dat)
        end
        // Output 0 follows selected first-word bit 2
        ds1 <= 16'h0004;
        repeat (3) @(posedge clk);
        `CHK("do0_no", 1'b1, do_no)
        `CHK("relay_fault", 1'b0, fault)
        axr(32'h14, rsp, dat);
        `CHK("do0_state", 32'h1, dat)
        // Every protection setting blocks the select write
        for (int p = 1; p < 4; p++) begin
            axw(32'h10, 32'(p), rsp);
            axw(32'h0C, DIDB_OUTSEL_RST, rsp);
            `CHK("prot_bresp", DIDB_RESP_SLVERR, rsp)
        end
        axr(32'h0C, rsp, dat);
        `CHK("prot_sel", 32'h2, dat)
        axw(32'h10, 32'h0, rsp);
        axw(32'h0C, DIDB_OUTSEL_RST, rsp);
        repeat (3) @(posedge clk);
        `CHK("do0_fault_bit", 1'b0, do_no)
        // Second status word: comparator bit 10 drives output 0
        ds2 <= 16'h0400;
        axw(32'h0C, 32'h2A, rsp);
        `CHK("sel_bresp", DIDB_RESP_OKAY, rsp)
        repeat (3) @(posedge clk);
        `CHK("do0_word_two", 1'b1, do_no)
        // Mid-run reset: relay rests, registers back to defaults
        axw(32'h10, 32'h1, rsp);
        ds1 <= 16'h0008;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("rst_no", 1'b0, do_no)
        `CHK("rst_nc", 1'b1, do_nc)
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("rst_fault_bit", 1'b1, do_no)
        axr(32'h10, rsp, dat);
        `CHK("rst_prot", 32'h0, dat)
        axr(32'h08, rsp, dat);
        `CHK("rst_debounce", DIDB_DEB_RST_US, dat)
        // Zero debounce time, new pattern with analog pair high before the first tick
        axw(32'h08, 32'h0, rsp);
        sw <= 8'hD5;
        repeat (4) @(posedge clk);
        axr(32'h00, rsp, dat);
        `CHK("plain_early", 32'h0, dat)
        while (cyc < 80100) @(posedge clk);
        axr(32'h00, rsp, dat);
        `CHK("plain", 32'h1815, dat)
        axr(32'h04, rsp, dat);
        `CHK("inverted", 32'h002A, dat)
        conclude();
    end
endmodule : didb_top_test
bind didb_top didb_top_checker didb_top_checker_i (.*);
